// file: rtl/seq_outputs_pkg.sv
// Constants and types shared by the sequenced general output block
package seq_outputs_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_OUT0_DELAYS = 8'h0c;
  localparam logic [7:0] IDX_OUT1_DELAYS = 8'h0d;
  localparam logic [7:0] IDX_OUT2_DELAYS = 8'h0e;
  localparam logic [7:0] IDX_OUT01_CTRL = 8'h0f;
  localparam logic [7:0] IDX_OUT2_CTRL = 8'h10;
  localparam logic [7:0] IDX_DELAY_SCALE = 8'h11;
  localparam logic [7:0] IDX_PIN_STATUS = 8'h12;
  localparam int ADDR_LSB = 2;

  // Reset values
  localparam logic [7:0] RST_DELAYS = 8'h00;
  localparam logic [7:0] RST_OUT01_CTRL = 8'haa;
  localparam logic [7:0] RST_OUT2_CTRL = 8'h0a;
  localparam logic [7:0] RST_DELAY_SCALE = 8'h00;

  // Field positions
  localparam int FALL_LSB = 4;
  localparam int RISE_LSB = 0;
  localparam int CH_CFG_W = 4;
  localparam int OUT1_CFG_LSB = 4;
  localparam int OUT1_FUNC_BIT = 4;
  localparam int OUT2_FUNC_BIT = 5;
  localparam int RISE_SCALE_BIT = 7;
  localparam int FALL_SCALE_BIT = 6;
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_PIN_LSB = 3;
  localparam int STAT_CTRL_LSB = 6;
  localparam logic [7:0] OUT2_CTRL_MASK = 8'h3f;
  localparam logic [7:0] SCALE_MASK = 8'hc0;

  localparam int NUM_OUT = 3;
  localparam int STEPS_W = 5;
  localparam int SUB_W = 14;

  // Time base: one delay step is half a millisecond at the base scale
  localparam int CLK_PERIOD_NS = 50;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // Gate selection of one output
  typedef enum logic [1:0] {
    GATE_NONE = 2'h0,
    GATE_PIN_ONE = 2'h1,
    GATE_PIN_TWO = 2'h2,
    GATE_PIN_THREE = 2'h3
  } gate_sel_t;

  // One output's control field group, as laid out in the control bytes
  typedef struct packed {
    logic drive_type;
    gate_sel_t gate;
    logic level;
  } ch_cfg_t;

  // Captured address phase of a bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } bus_req_t;

endpackage

// file: rtl/sequenced_general_outputs.sv
// Three sequenced general outputs with edge delays behind an AHB-Lite slave
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bits 7-4 of each delay byte set shutdown delay after falling control edge; 0 none.
// - Bits 3-0 of each delay byte set startup delay after rising control edge.
// - Delay code n gives n times 0.5 ms, or n times 1 ms when scaled.
// - Delay bytes for outputs zero, one, two sit at Ch, Dh, Eh, reset zero.
// - Gate select 0 uses level bit alone; 1-3 AND it with enable pin one-three.
// - Output zero follows its level bit, after gating and programmed delays.
// - Output one level bit drives shared pin only in general output mode.
// - Drive-type bit 3 (output zero) or 7 (output one): 0 push-pull, 1 open-drain.
// - Control byte resets to AAh and every field is read/write.
// - Startup scale bit: clear 0.5 ms steps up to 7.5 ms, set 1 ms to 15 ms.
// - A separate shutdown scale bit sets shutdown step size the same way.
module sequenced_general_outputs #(
  parameter int HALF_MS_CYCLES = seq_outputs_pkg::HALF_MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic enable_pin_one,
  input wire logic enable_pin_two,
  input wire logic enable_pin_three,
  input wire logic power_good_one,
  input wire logic aux_output_zero_i,
  output logic aux_output_zero_o,
  output logic aux_output_zero_oe,
  input wire logic aux_output_one_i,
  output logic aux_output_one_o,
  output logic aux_output_one_oe,
  input wire logic aux_output_two_i,
  output logic aux_output_two_o,
  output logic aux_output_two_oe
);
  import seq_outputs_pkg::*;

  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(HALF_MS_CYCLES - 1);

  // Register file
  logic [7:0] delays_q [NUM_OUT];
  logic [7:0] out01_ctrl_q;
  logic [7:0] out2_ctrl_q;
  logic [7:0] scale_q;

  // Bus slave state
  bus_req_t req_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] hrdata_q;

  // Synchronisers for pins from outside the clock domain
  logic [NUM_OUT-1:0] en_meta_q;
  logic [NUM_OUT-1:0] en_sync_q;
  logic [NUM_OUT-1:0] pin_meta_q;
  logic [NUM_OUT-1:0] pin_sync_q;

  // Per output sequencing state
  ch_cfg_t cfg [NUM_OUT];
  logic [NUM_OUT-1:0] ctrl_sig;
  logic [NUM_OUT-1:0] ctrl_prev_q;
  logic [NUM_OUT-1:0] pend_q;
  logic [NUM_OUT-1:0] target_q;
  logic [NUM_OUT-1:0] level_q;
  logic [STEPS_W-1:0] steps_left_q [NUM_OUT];
  logic [SUB_W-1:0] sub_q [NUM_OUT];

  // Pin drivers
  logic [NUM_OUT-1:0] drive_level;
  logic [NUM_OUT-1:0] drive_on;
  logic [NUM_OUT-1:0] pin_o_q;
  logic [NUM_OUT-1:0] pin_oe_q;

  logic out1_general;
  logic out2_general;
  logic [7:0] rd_byte;

  assign cfg[0] = ch_cfg_t'(out01_ctrl_q[CH_CFG_W-1:0]);
  assign cfg[1] = ch_cfg_t'(out01_ctrl_q[OUT1_CFG_LSB +: CH_CFG_W]);
  assign cfg[2] = ch_cfg_t'(out2_ctrl_q[CH_CFG_W-1:0]);
  assign out1_general = out2_ctrl_q[OUT1_FUNC_BIT];
  assign out2_general = out2_ctrl_q[OUT2_FUNC_BIT];

  // Two flops on the enable pins and output pin inputs before use; power_good_one is not synchronised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_meta_q <= '0;
      en_sync_q <= '0;
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (clk_en) begin
      en_meta_q <= {enable_pin_three, enable_pin_two, enable_pin_one};
      en_sync_q <= en_meta_q;
      pin_meta_q <= {aux_output_two_i, aux_output_one_i, aux_output_zero_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Address phase capture; runs even with clk_en low since the master has moved on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready && hreadyout_q) begin
      req_q.valid <= hsel && (htrans == HTRANS_NONSEQ);
      req_q.write <= hwrite;
      req_q.index <= haddr[ADDR_LSB +: 8];
    end else if (clk_en) begin
      req_q.valid <= 1'b0;
    end
  end

  // One wait state per transfer; held off while the block is frozen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else if (hready && hreadyout_q && hsel && (htrans == HTRANS_NONSEQ)) begin
      hreadyout_q <= 1'b0;
    end else if (clk_en) begin
      hreadyout_q <= 1'b1;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (req_q.index)
      IDX_OUT0_DELAYS: rd_byte = delays_q[0];
      IDX_OUT1_DELAYS: rd_byte = delays_q[1];
      IDX_OUT2_DELAYS: rd_byte = delays_q[2];
      IDX_OUT01_CTRL: rd_byte = out01_ctrl_q;
      IDX_OUT2_CTRL: rd_byte = out2_ctrl_q;
      IDX_DELAY_SCALE: rd_byte = scale_q;
      IDX_PIN_STATUS: begin
        rd_byte[STAT_LEVEL_LSB +: NUM_OUT] = level_q;
        rd_byte[STAT_PIN_LSB +: NUM_OUT] = pin_sync_q;
        rd_byte[STAT_CTRL_LSB +: 2] = ctrl_prev_q[1:0];
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data; unmapped indices read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (clk_en && req_q.valid && !req_q.write) begin
      hrdata_q <= {24'h000000, rd_byte};
    end
  end

  // Register writes in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        delays_q[i] <= RST_DELAYS;
      end
      out01_ctrl_q <= RST_OUT01_CTRL;
      out2_ctrl_q <= RST_OUT2_CTRL;
      scale_q <= RST_DELAY_SCALE;
    end else if (clk_en && req_q.valid && req_q.write) begin
      unique case (req_q.index)
        IDX_OUT0_DELAYS: delays_q[0] <= hwdata[7:0];
        IDX_OUT1_DELAYS: delays_q[1] <= hwdata[7:0];
        IDX_OUT2_DELAYS: delays_q[2] <= hwdata[7:0];
        IDX_OUT01_CTRL: out01_ctrl_q <= hwdata[7:0];
        IDX_OUT2_CTRL: out2_ctrl_q <= hwdata[7:0] & OUT2_CTRL_MASK;
        IDX_DELAY_SCALE: scale_q <= hwdata[7:0] & SCALE_MASK;
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gen_ch
      logic [3:0] code;
      logic scale;
      logic [STEPS_W-1:0] steps;

      // Control signal: level bit, optionally ANDed with one enable pin
      always_comb begin
        unique case (cfg[g].gate)
          GATE_NONE: ctrl_sig[g] = cfg[g].level;
          GATE_PIN_ONE: ctrl_sig[g] = cfg[g].level & en_sync_q[0];
          GATE_PIN_TWO: ctrl_sig[g] = cfg[g].level & en_sync_q[1];
          GATE_PIN_THREE: ctrl_sig[g] = cfg[g].level & en_sync_q[2];
        endcase
      end

      // Code and step size picked by the direction of the new edge
      always_comb begin
        if (ctrl_sig[g]) begin
          code = delays_q[g][RISE_LSB +: 4];
          scale = scale_q[RISE_SCALE_BIT];
        end else begin
          code = delays_q[g][FALL_LSB +: 4];
          scale = scale_q[FALL_SCALE_BIT];
        end
        steps = scale ? {code, 1'b0} : {1'b0, code};
      end

      // A fresh edge always restarts timing, cancelling any pending one
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctrl_prev_q[g] <= 1'b0;
          pend_q[g] <= 1'b0;
          target_q[g] <= 1'b0;
          level_q[g] <= 1'b0;
          steps_left_q[g] <= '0;
          sub_q[g] <= '0;
        end else if (clk_en) begin
          if (ctrl_sig[g] != ctrl_prev_q[g]) begin
            ctrl_prev_q[g] <= ctrl_sig[g];
            target_q[g] <= ctrl_sig[g];
            sub_q[g] <= '0;
            steps_left_q[g] <= steps;
            if (steps == '0) begin
              level_q[g] <= ctrl_sig[g];
              pend_q[g] <= 1'b0;
            end else begin
              pend_q[g] <= 1'b1;
            end
          end else if (pend_q[g]) begin
            if (sub_q[g] == SUB_LAST) begin
              sub_q[g] <= '0;
              steps_left_q[g] <= steps_left_q[g] - STEPS_W'(1);
              if (steps_left_q[g] == STEPS_W'(1)) begin
                level_q[g] <= target_q[g];
                pend_q[g] <= 1'b0;
              end
            end else begin
              sub_q[g] <= sub_q[g] + SUB_W'(1);
            end
          end
        end
      end

      // Open-drain only sinks; push-pull drives both levels
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_o_q[g] <= 1'b0;
          pin_oe_q[g] <= 1'b0;
        end else if (clk_en) begin
          if (!drive_on[g]) begin
            pin_o_q[g] <= 1'b0;
            pin_oe_q[g] <= 1'b0;
          end else if (cfg[g].drive_type) begin
            pin_o_q[g] <= 1'b0;
            pin_oe_q[g] <= ~drive_level[g];
          end else begin
            pin_o_q[g] <= drive_level[g];
            pin_oe_q[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Shared pin shows the power-good input unless set to general output
  assign drive_level[0] = level_q[0];
  assign drive_level[1] = out1_general ? level_q[1] : power_good_one;
  assign drive_level[2] = level_q[2];
  assign drive_on[0] = 1'b1;
  assign drive_on[1] = 1'b1;
  // Output two pin is released while it serves as a clock input
  assign drive_on[2] = out2_general;

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign aux_output_zero_o = pin_o_q[0];
  assign aux_output_zero_oe = pin_oe_q[0];
  assign aux_output_one_o = pin_o_q[1];
  assign aux_output_one_oe = pin_oe_q[1];
  assign aux_output_two_o = pin_o_q[2];
  assign aux_output_two_oe = pin_oe_q[2];

endmodule

`default_nettype wire

// file: sim/sgo_checker_assertions.sv
// Checker for bus timing and pin drive of the sequenced outputs
`timescale 1ns/1ps
`default_nettype none
module sgo_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic aux_output_zero_o,
  input wire logic aux_output_zero_oe,
  input wire logic aux_output_one_o,
  input wire logic aux_output_one_oe
);
  import seq_outputs_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire taken = hsel && htrans == HTRANS_NONSEQ && hready && hreadyout;
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("bad response");
  property p_wait; taken |=> !hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_done; !hreadyout && clk_en |=> hreadyout; endproperty
  a_done: assert property (p_done) else $error("data phase too long");
  // A wait state raised with no transfer taken would stall the whole bus
  property p_idle; hreadyout && !taken |=> hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("ready dropped");
  property p_upper; hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_od0; !aux_output_zero_oe |-> !aux_output_zero_o; endproperty
  a_od0: assert property (p_od0) else $error("out0 high undriven");
  property p_od1; $rose(aux_output_one_o) |-> aux_output_one_oe; endproperty
  a_od1: assert property (p_od1) else $error("out1 high undriven");
  cover property (taken);
  cover property ($rose(aux_output_zero_o));
  cover property ($fell(aux_output_one_oe));
endmodule
bind sequenced_general_outputs sgo_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .aux_output_zero_o(aux_output_zero_o),
  .aux_output_zero_oe(aux_output_zero_oe), .aux_output_one_o(aux_output_one_o),
  .aux_output_one_oe(aux_output_one_oe));
`default_nettype wire

// file: sim/pin_loads.sv
// Board loads on the three output pins
`timescale 1ns/1ps
`default_nettype none
module pin_loads (
  input wire logic [2:0] drv_o,
  input wire logic [2:0] drv_oe,
  output logic [2:0] pin_lvl
);
  // Pull-ups, so a released open-drain pin reads high
  assign pin_lvl = ~drv_oe | drv_o;
endmodule
`default_nettype wire

// file: sim/sequenced_general_outputs_bench.sv
// Self-checking bench for the sequenced general outputs
`timescale 1ns/1ps
`default_nettype none
module sequenced_general_outputs_bench;
  import seq_outputs_pkg::*;
  localparam int HALF = 4;
  logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0, pg = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, en = 3'h0, po, poe, pin;
  logic hreadyout, hresp;
  int errors = 0, check_count = 0, cyc = 0;
  always #25 hclk = ~hclk;
  sequenced_general_outputs #(.HALF_MS_CYCLES(HALF)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .enable_pin_one(en[0]), .enable_pin_two(en[1]),
    .enable_pin_three(en[2]), .power_good_one(pg), .aux_output_zero_i(pin[0]),
    .aux_output_zero_o(po[0]), .aux_output_zero_oe(poe[0]), .aux_output_one_i(pin[1]),
    .aux_output_one_o(po[1]), .aux_output_one_oe(poe[1]), .aux_output_two_i(pin[2]),
    .aux_output_two_o(po[2]), .aux_output_two_oe(poe[2]));
  pin_loads u_load (.drv_o(po), .drv_oe(poe), .pin_lvl(pin));
  task automatic test_done;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask
  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask
  // Bounded wait; 200 means the pin never moved
  task automatic wait_pin(input logic v, output int n);
    n = 0;
    while (po[0] !== v && n < 200) begin
      @(posedge hclk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset;
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, IDX_OUT0_DELAYS + 8'(i), 32'h0, r);
      check(r, i == 3 ? 32'(RST_OUT01_CTRL) : 32'(RST_DELAYS));
    end
    check({po[0], poe[0]}, 2'h1);
  endtask
  task automatic t_rw;
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_OUT0_DELAYS + 8'(i), 32'hffffff5a + 32'(i));
      xfer(1'b0, IDX_OUT0_DELAYS + 8'(i), 32'h0, r);
      check(r, 32'h5a + 32'(i));
    end
    wr(8'h3f, 32'hff);
    xfer(1'b0, 8'h3f, 32'h0, r);
    check(r, 32'h0);
  endtask
  task automatic t_gate;
    wr(IDX_OUT0_DELAYS, 32'h0);
    for (int g = 1; g < 4; g++) begin
      en <= ~(3'h1 << (g - 1));
      wr(IDX_OUT01_CTRL, 32'((g << 1) | 1));
      settle;
      check(po[0], 1'h0);
      en <= 3'h1 << (g - 1);
      settle;
      check(po[0], 1'h1);
    end
    wr(IDX_OUT01_CTRL, 32'h0);
    settle;
    check(po[0], 1'h0);
  endtask
  task automatic t_delay;
    logic [7:0] sc [3] = '{8'h00, 8'h80, 8'h40};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(IDX_DELAY_SCALE, 32'(sc[i]));
      wr(IDX_OUT0_DELAYS, 32'h31);
      wr(IDX_OUT01_CTRL, 32'h1);
      wait_pin(1'h1, n);
      check(n, (sc[i][7] + 1) * HALF + 1);
      wr(IDX_OUT01_CTRL, 32'h0);
      wait_pin(1'h0, n);
      check(n, 3 * (sc[i][6] + 1) * HALF + 1);
    end
    wr(IDX_OUT0_DELAYS, 32'h3f);
    wr(IDX_OUT01_CTRL, 32'h1);
    wr(IDX_OUT01_CTRL, 32'h0);
    wait_pin(1'h1, n);
    check(n, 200);
  endtask
  task automatic t_drive;
    // Leftover delay codes from earlier scenarios would hold the pins back
    wr(IDX_OUT0_DELAYS, 32'h0);
    wr(IDX_OUT1_DELAYS, 32'h0);
    wr(IDX_OUT01_CTRL, 32'h09);
    settle;
    check({po[0], poe[0], pin[0]}, 3'h1);
    wr(IDX_OUT01_CTRL, 32'h08);
    settle;
    check({po[0], poe[0], pin[0]}, 3'h2);
    wr(IDX_OUT2_CTRL, 32'h10);
    wr(IDX_OUT01_CTRL, 32'h10);
    settle;
    check({po[1], poe[1]}, 2'h3);
    wr(IDX_OUT01_CTRL, 32'h90);
    settle;
    check({po[1], poe[1]}, 2'h0);
    wr(IDX_OUT2_CTRL, 32'h0);
    settle;
    check(poe[1], 1'h1);
    pg <= 1'b1;
    settle;
    check(poe[1], 1'h0);
  endtask
  task automatic t_out2;
    logic [31:0] r;
    wr(IDX_OUT2_DELAYS, 32'h0);
    wr(IDX_OUT2_CTRL, 32'h21);
    settle;
    check({po[2], poe[2], pin[2]}, 3'h7);
    wr(IDX_OUT2_CTRL, 32'h01);
    settle;
    check({po[2], poe[2], pin[2]}, 3'h1);
    // Levels 110, pins 110, controls 10
    xfer(1'b0, IDX_PIN_STATUS, 32'h0, r);
    check(r, 32'hb6);
    wr(IDX_DELAY_SCALE, 32'hff);
    xfer(1'b0, IDX_DELAY_SCALE, 32'h0, r);
    check(r, 32'(SCALE_MASK));
  endtask
  // A frozen block must not count its delay
  task automatic t_freeze;
    int n;
    wr(IDX_DELAY_SCALE, 32'h0);
    wr(IDX_OUT0_DELAYS, 32'h01);
    wr(IDX_OUT01_CTRL, 32'h91);
    clk_en <= 1'b0;
    repeat (20) @(posedge hclk);
    check(po[0], 1'h0);
    clk_en <= 1'b1;
    wait_pin(1'h1, n);
    check(n, HALF + 1);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_rw;
    t_gate;
    t_delay;
    t_drive;
    t_out2;
    t_freeze;
    test_done;
  end
endmodule
`default_nettype wire
